// ---- hdl/pcs_pll_regs.vh ----
// Constants for the clock-synthesis control block.
// Assumes inclusion by the single design file under hdl/.
`ifndef PCS_PLL_REGS_VH
`define PCS_PLL_REGS_VH
// Feedback source select codes.
`define PCS_FB_INTERNAL 2'h0
`define PCS_FB_GLOBAL 2'h1
`define PCS_FB_POSTSCALE 2'h2
`define PCS_FB_ROUTING 2'h3
// Divider field width and reset value (divide by one).
`define PCS_DIV_W 6
`define PCS_DIV_ONE 6'h00
// Synchroniser width (one bit per source clock) and delay line taps.
`define PCS_SYNC_W 6
`define PCS_TAPS 16
// Delay and phase field widths and reset values.
`define PCS_DLY_W 4
`define PCS_DLY_RST 4'h0
`define PCS_PH_W 3
`define PCS_PH_RST 3'h0
`define PCS_DUTY_RST 3'h3
// Lock acquisition time in ns, and cycles at 5 ns per cycle (rounded up).
`define PCS_LOCK_NS 1000
`define PCS_CLK_NS 5
`define PCS_LOCK_CYC ((`PCS_LOCK_NS + `PCS_CLK_NS - 1) / `PCS_CLK_NS)
`define PCS_LOCK_W 10
`endif

// ---- hdl/pcs_pll_ctrl.v ----
// Clock-synthesis control: dividers, source selection, path delay,
// secondary phase/duty stage and lock indication. Runs on mclk; reference
// clocks are sampled through two-flop synchronisers as plain inputs.
// Notes on behaviour
// - Input divider reference selects external pin or internal routing.
// - Feedback divider chooses among four sources.
// - Lock output asserts 200 mclk cycles after the last reconfiguration, whatever the reference does.
// - Programmable delay goes in feedback path or input path.
// - Delay loaded at configuration or adjusted at run time dynamically.
// - Dynamic delay change drops lock until acquire time elapses.
// - Secondary output has adjustable phase and duty cycle.
// - Four dividers: input, feedback, post-scalar, secondary.
// - Input divider divides reference; feedback ratio sets multiplication.
// - Post-scalar divides oscillator down to the primary output.
// - Secondary divider produces lower-frequency derived clocks.
// - Four clock outputs toward fabric and global nets.
`timescale 1ns/1ps
`include "pcs_pll_regs.vh"
module pcs_pll_ctrl
(
  // Clock and reset.
  input wire mclk,
  input wire rst,
  // Reference sources (asynchronous pins).
  input wire ref_pin,
  input wire ref_routing,
  input wire ref_select_routing,
  // Oscillator and feedback sources.
  input wire osc_clk,
  input wire internal_feedback_port,
  input wire global_fb,
  input wire routing_fb,
  input wire [1:0] fb_select,
  // Divider settings, ratio minus one.
  input wire [`PCS_DIV_W-1:0] in_div,
  input wire [`PCS_DIV_W-1:0] fb_div,
  input wire [`PCS_DIV_W-1:0] post_div,
  input wire [`PCS_DIV_W-1:0] sec_div,
  // Path delay control.
  input wire delay_in_feedback,
  input wire [`PCS_DLY_W-1:0] config_delay,
  input wire dynamic_mode,
  input wire [`PCS_DLY_W-1:0] dynamic_delay,
  input wire dynamic_load,
  // Secondary phase and duty, in eighths of its period.
  input wire [`PCS_PH_W-1:0] sec_phase,
  input wire [`PCS_PH_W-1:0] sec_duty,
  // Outputs.
  output reg ref_divided,
  output reg fb_divided,
  output reg primary_clock_output,
  output reg secondary_clock_output,
  output reg secondary_raw_output,
  output reg feedback_delayed,
  output reg pll_locked,
  output reg [`PCS_DLY_W-1:0] active_delay
);

// ******************************
// Synchronisers.
// ******************************
// Every source clock is a level on a pin, unrelated to mclk. Two flops
// keep metastability out of the edge detectors; only the second stage
// is read by any logic.
reg [`PCS_SYNC_W-1:0] sync_a;
reg [`PCS_SYNC_W-1:0] sync_b;
wire [`PCS_SYNC_W-1:0] async_in;
assign async_in = {ref_pin, ref_routing, osc_clk, internal_feedback_port,
  global_fb, routing_fb};
always @(posedge mclk)
begin
  if (rst)
  begin
    sync_a <= {`PCS_SYNC_W{1'b0}};
    sync_b <= {`PCS_SYNC_W{1'b0}};
  end
  else
  begin
    sync_a <= async_in;
    sync_b <= sync_a;
  end
end
wire s_ref_pin = sync_b[5];
wire s_ref_rt = sync_b[4];
wire s_osc = sync_b[3];
wire s_fb_int = sync_b[2];
wire s_fb_glb = sync_b[1];
wire s_fb_rt = sync_b[0];

// ******************************
// Edge detection and source selection.
// ******************************
// Rising edges are found by comparing a synchronised level with its
// value one cycle back. The history flops reset low, matching a source
// that idles low, so no false edge follows reset.
reg ref_q;
reg osc_q;
reg fb_q;
wire ref_src = ref_select_routing ? s_ref_rt : s_ref_pin;
// Post-scalar feedback is taken straight from the registered primary
// output, so it needs no synchroniser.
reg fb_src;
always @*
begin
  case (fb_select)
    `PCS_FB_INTERNAL: fb_src = s_fb_int;
    `PCS_FB_GLOBAL: fb_src = s_fb_glb;
    `PCS_FB_POSTSCALE: fb_src = primary_clock_output;
    `PCS_FB_ROUTING: fb_src = s_fb_rt;
    default: fb_src = s_fb_int;
  endcase
end
always @(posedge mclk)
begin
  if (rst)
  begin
    ref_q <= 1'b0;
    osc_q <= 1'b0;
    fb_q <= 1'b0;
  end
  else
  begin
    ref_q <= ref_src;
    osc_q <= s_osc;
    fb_q <= fb_src;
  end
end
wire ref_rise = ref_src & ~ref_q;
wire osc_rise = s_osc & ~osc_q;
wire fb_rise = fb_src & ~fb_q;

// ******************************
// Four dividers: toggle output every (ratio) source edges.
// ******************************
// Each counter runs from zero to its ratio-minus-one setting and then
// wraps; the tick on the wrap toggles the divided output, so the output
// period is twice the ratio in source edges.
wire [3:0] div_tick;
wire [`PCS_DIV_W-1:0] div_lim [0:3];
assign div_lim[0] = in_div;
assign div_lim[1] = fb_div;
assign div_lim[2] = post_div;
assign div_lim[3] = sec_div;
wire [3:0] div_edge;
// Secondary divider counts post-scalar output edges.
wire prim_rise = div_tick[2] & ~primary_clock_output;
assign div_edge = {prim_rise, osc_rise, fb_rise, ref_rise};
genvar gi;
generate
  for (gi = 0; gi < 4; gi = gi + 1)
  begin : g_div
    // Counters live inside the loop so each has a single driver.
    reg [`PCS_DIV_W-1:0] cnt;
    assign div_tick[gi] = div_edge[gi] && (cnt == div_lim[gi]);
    always @(posedge mclk)
    begin
      if (rst)
        cnt <= `PCS_DIV_ONE;
      else if (div_edge[gi])
        cnt <= (cnt == div_lim[gi]) ? `PCS_DIV_ONE :
          cnt + 1'b1;
    end
  end
endgenerate

// ******************************
// Path delay selection and delay line.
// ******************************
// The delay line is a shift register of mclk taps fed by the selected
// path. A setting of zero bypasses it. Static mode follows config_delay
// every cycle; dynamic mode keeps its value until a load strobe.
reg [`PCS_DLY_W-1:0] next_delay;
reg [`PCS_TAPS-1:0] dly_line;
always @*
begin
  next_delay = active_delay;
  if (!dynamic_mode)
    next_delay = config_delay;
  else if (dynamic_load)
    next_delay = dynamic_delay;
end
wire delay_change = next_delay != active_delay;
wire ref_path = ref_divided ^ div_tick[0];
wire fb_path = fb_divided ^ div_tick[1];
// Delay is inserted in one path only.
wire dly_src = delay_in_feedback ? fb_path : ref_path;
wire dly_out = (active_delay == `PCS_DLY_RST) ? dly_src :
  dly_line[active_delay - 1'b1];

// ******************************
// Secondary phase and duty stage.
// ******************************
// The secondary stage counts primary output rises modulo eight; the
// output is high for sec_duty eighths, starting sec_phase eighths in.
reg [`PCS_PH_W-1:0] sec_pos;
wire [`PCS_PH_W-1:0] sec_rel = sec_pos - sec_phase;
always @(posedge mclk)
begin
  if (rst)
  begin
    dly_line <= {`PCS_TAPS{1'b0}};
    active_delay <= `PCS_DLY_RST;
    ref_divided <= 1'b0;
    fb_divided <= 1'b0;
    primary_clock_output <= 1'b0;
    secondary_raw_output <= 1'b0;
    secondary_clock_output <= 1'b0;
    feedback_delayed <= 1'b0;
    sec_pos <= `PCS_PH_RST;
  end
  else
  begin
    dly_line <= {dly_line[`PCS_TAPS-2:0], dly_src};
    active_delay <= next_delay;
    ref_divided <= ref_path;
    fb_divided <= fb_path;
    if (div_tick[2])
      primary_clock_output <= ~primary_clock_output;
    if (div_tick[3])
      secondary_raw_output <= ~secondary_raw_output;
    feedback_delayed <= dly_out;
    if (prim_rise)
      sec_pos <= sec_pos + 1'b1;
    secondary_clock_output <= sec_rel < sec_duty;
  end
end

// ******************************
// Lock indicator.
// ******************************
// The lock time is counted in mclk cycles from the last change of any
// divider, source select or delay. A change in mid-count restarts it, so
// consumers never see lock while the loop may still be settling.
localparam [1:0] ST_ACQUIRE = 2'b01;
localparam [1:0] ST_LOCKED = 2'b10;
localparam integer LOCK_LAST = `PCS_LOCK_CYC - 1;
wire [`PCS_LOCK_W-1:0] lock_last = LOCK_LAST[`PCS_LOCK_W-1:0];
reg [1:0] lock_state;
reg [1:0] next_lock_state;
reg [`PCS_LOCK_W-1:0] lock_cnt;
reg [`PCS_LOCK_W-1:0] next_lock_cnt;
reg next_locked;
reg [`PCS_DIV_W*4+3:0] cfg_q;
wire [`PCS_DIV_W*4+3:0] cfg_now = {in_div, fb_div, post_div, sec_div,
  fb_select, ref_select_routing, delay_in_feedback};
// cfg_q starts at zero, so the first cycle after reset restarts the count unless cfg_now is zero.
wire reconfig = (cfg_now != cfg_q) || delay_change;
always @*
begin
  next_lock_state = lock_state;
  next_lock_cnt = lock_cnt;
  next_locked = pll_locked;
  case (lock_state)
    ST_ACQUIRE:
    begin
      if (lock_cnt == lock_last)
      begin
        next_lock_state = ST_LOCKED;
        next_locked = 1'b1;
      end
      else
        next_lock_cnt = lock_cnt + 1'b1;
    end
    ST_LOCKED:
      next_locked = 1'b1;
    default:
    begin
      next_lock_state = ST_ACQUIRE;
      next_lock_cnt = {`PCS_LOCK_W{1'b0}};
      next_locked = 1'b0;
    end
  endcase
  // Any reconfiguration wins over the count and over a held lock.
  if (reconfig)
  begin
    next_lock_state = ST_ACQUIRE;
    next_lock_cnt = {`PCS_LOCK_W{1'b0}};
    next_locked = 1'b0;
  end
end
always @(posedge mclk)
begin
  if (rst)
  begin
    lock_state <= ST_ACQUIRE;
    cfg_q <= {(`PCS_DIV_W*4+4){1'b0}};
    lock_cnt <= {`PCS_LOCK_W{1'b0}};
    pll_locked <= 1'b0;
  end
  else
  begin
    lock_state <= next_lock_state;
    cfg_q <= cfg_now;
    lock_cnt <= next_lock_cnt;
    pll_locked <= next_locked;
  end
end

endmodule

// ---- verification/pcs_far_side.sv ----
// Far-side model: free-running source clocks and lock consumer.
// Assumes the bench waits for lock through clk_usable; it also reads pll_locked directly.
`timescale 1ns/1ps
module pcs_far_side
(
  // Lock status in.
  input wire pll_locked,
  // Clock sources out.
  output reg ref_pin = 1'h0,
  output reg ref_routing = 1'h0,
  output reg osc_clk = 1'h0,
  output reg internal_feedback_port = 1'h0,
  output reg global_fb = 1'h0,
  output reg routing_fb = 1'h0,
  output wire clk_usable
);
  // ****
  // Periods unrelated to mclk.
  // ****
  always #11 ref_pin = ~ref_pin;
  always #13 ref_routing = ~ref_routing;
  always #7 osc_clk = ~osc_clk;
  always #9 internal_feedback_port = ~internal_feedback_port;
  always #15 global_fb = ~global_fb;
  always #17 routing_fb = ~routing_fb;
  // The clock counts as unlocked until lock reasserts.
  assign clk_usable = pll_locked;
endmodule

// ---- verification/pcs_pll_chk.sv ----
// Checker on the block ports.
// Assumes binding into pcs_pll_ctrl.
`timescale 1ns/1ps
module pcs_pll_chk
(
  // Settings.
  input wire mclk,
  input wire rst,
  input wire ref_select_routing,
  input wire [1:0] fb_select,
  input wire [5:0] in_div,
  input wire [5:0] fb_div,
  input wire [5:0] post_div,
  input wire [5:0] sec_div,
  input wire delay_in_feedback,
  input wire [3:0] config_delay,
  input wire dynamic_mode,
  input wire [3:0] dynamic_delay,
  input wire dynamic_load,
  // Status.
  input wire pll_locked,
  input wire [3:0] active_delay
);
  // ****
  // Cycles since lock was restarted.
  // ****
  wire [27:0] cfg = {ref_select_routing, fb_select, in_div, fb_div,
    post_div, sec_div, delay_in_feedback};
  // A delay change is a new value in the source that the mode selects.
  wire ld = dynamic_mode ? dynamic_load && dynamic_delay != active_delay :
    config_delay != active_delay;
  reg [7:0] cnt;
  always @(posedge mclk)
    if (rst || !$stable(cfg) || ld)
      cnt <= 8'h00;
    else if (cnt != 8'hff)
      cnt <= cnt + 8'h01;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_reset_quiet: assert property (
    $fell(rst) |-> !pll_locked && active_delay == 4'h0) else $error("rst");
  a_cfg_drops: assert property (
    !$stable(cfg) |-> ##[1:2] !pll_locked) else $error("kept");
  a_lock_early: assert property (
    pll_locked |-> cnt > 8'hc2 || cnt < 8'h03) else $error("early");
  a_lock_late: assert property (
    cnt == 8'hd2 |-> pll_locked) else $error("late");
  a_lock_holds: assert property (
    pll_locked && !ld && cnt > 8'h03 && $stable(cfg) |=> pll_locked)
    else $error("lost");
  a_static_delay: assert property (
    (!dynamic_mode && $stable(config_delay)) [*3]
    |-> active_delay == config_delay) else $error("static");
  a_dyn_refused: assert property (
    (dynamic_mode && !dynamic_load) [*3] |-> $stable(active_delay))
    else $error("moved");
  a_dyn_drop: assert property (
    ld |-> ##[1:3] !pll_locked) else $error("held");
endmodule
bind pcs_pll_ctrl pcs_pll_chk chk (.*);

// ---- verification/tb_pll_clock_synthesis_control.sv ----
// Bench for pcs_pll_ctrl.
// Assumes the far-side model and the bound checker.
`timescale 1ns/1ps
module tb_pll_clock_synthesis_control;
  // ****
  // Stimulus and watched outputs.
  // ****
  reg mclk = 1'h0, rst = 1'h1, ref_select_routing = 1'h0, clr = 1'h0;
  reg delay_in_feedback = 1'h0, dynamic_mode = 1'h0, dynamic_load = 1'h0;
  reg [1:0] fb_select = 2'h3;
  reg [5:0] in_div = 6'h01, fb_div = 6'h01, post_div = 6'h01;
  reg [5:0] sec_div = 6'h00, seen = 6'h00, prev = 6'h00;
  reg [3:0] config_delay = 4'h0, dynamic_delay = 4'h0;
  reg [2:0] sec_phase = 3'h2, sec_duty = 3'h3;
  wire ref_pin, ref_routing, osc_clk, internal_feedback_port, global_fb;
  wire routing_fb, clk_usable, ref_divided, fb_divided, pll_locked;
  wire primary_clock_output, secondary_clock_output, secondary_raw_output;
  wire feedback_delayed;
  wire [3:0] active_delay;
  wire [5:0] outs = {ref_divided, fb_divided, primary_clock_output,
    secondary_clock_output, secondary_raw_output, feedback_delayed};
  integer errors = 0, comparisons = 0, n, i;
  pcs_pll_ctrl dut (.*);
  pcs_far_side far (.*);
  always #2.5 mclk = ~mclk;
  always @(posedge mclk) prev <= outs;
  always @(posedge mclk) seen <= clr ? 6'h00 : seen | (outs ^ prev);
  task step;
    @(posedge mclk) #1;
  endtask
  task check(input [7:0] got, input [7:0] exp);
  begin
    comparisons = comparisons + 1;
    errors = errors + (got !== exp);
    if (got !== exp)
      $display("wrong value at %0t: %h not %h", $time, got, exp);
  end
  endtask
  task complete_run;
  begin
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  end
  endtask
  // Lock must drop, come back after the lock time, and all clocks run.
  task relock;
  begin
    clr = 1'h1;
    step;
    clr = 1'h0;
    step;
    check({7'h00, pll_locked}, 8'h00);
    for (n = 2; clk_usable !== 1'h1 && n < 400; n = n + 1)
      step;
    check({7'h00, n > 194 && n < 207}, 8'h01);
    check({2'h0, seen}, 8'h3f);
  end
  endtask
  initial
  begin
    repeat (10) step;
    rst = 1'h0;
    check({1'h0, outs, pll_locked}, 8'h00);
    relock;
    $display("test 1 done");
    for (i = 0; i < 8; i = i + 1)
    begin
      fb_select = i[1:0];
      ref_select_routing = i[2];
      relock;
    end
    $display("test 2 done");
    post_div = 6'h02;
    relock;
    config_delay = 4'hf;
    delay_in_feedback = 1'h1;
    relock;
    check({4'h0, active_delay}, 8'h0f);
    dynamic_mode = 1'h1;
    dynamic_load = 1'h1;
    dynamic_delay = 4'h9;
    step;
    dynamic_load = 1'h0;
    dynamic_delay = 4'h2;
    relock;
    check({4'h0, active_delay}, 8'h09);
    $display("test 3 done");
    complete_run;
  end
  // About 2500 cycles of tests; the limit is far beyond that.
  initial
  begin
    #150000;
    errors = errors + 1;
    complete_run;
  end
endmodule
